// >>> verilog/sioc_consts.vh
// Constants for the serial port and infrared option configuration block
// Operation
// - Mode register bit 0 enables music-interface mode; reset off.
// - Mode register bit 1 enables high speed for that port; reset off.
// - First port mode bit 7 makes both ports share one interrupt.
// - Sharing with two different pins assigned drives both pins on either interrupt.
// - First port mode bits 6..2 reserved, written zero, no function.
// - Second port mode bits 7..2 reserved, written zero, no sharing control.
// - Infrared bit 0 inverts receive input when set; reset active high.
// - Infrared bit 1 inverts transmit output when set; reset active low.
// - Infrared bit 2 selects half duplex when set; reset full duplex.
// - Infrared bits 5..3: 000 standard serial, 001 infrared, others reserved.
// - Infrared bit 6 moves infrared to alternate pins; reset normal pins.
// - Infrared bit 7 reserved, written zero, no function.
// - Timeout register adds blanking in 100 us steps, 0 to 25.5 ms.
// - Value zero blanks only during activity; each step adds 100 us.
`ifndef SIOC_CONSTS_VH
`define SIOC_CONSTS_VH

// ****************************************
// Register indices, byte address = 4 * index
// ****************************************
`define SIOC_IDX_LDN      8'h07
`define SIOC_IDX_MODE     8'hf0
`define SIOC_IDX_IROPT    8'hf1
`define SIOC_IDX_IRTMO    8'hf2
`define SIOC_IDX_ISTS     8'hf8
`define SIOC_IDX_IMSK     8'hf9
`define SIOC_IDX_STATE    8'hfa

// ****************************************
// Logical device numbers
// ****************************************
`define SIOC_LDN_FIRST    8'h04
`define SIOC_LDN_SECOND   8'h05

// ****************************************
// Field positions
// ****************************************
`define SIOC_MODE_MIDI    0
`define SIOC_MODE_HS      1
`define SIOC_MODE_SHARE   7
`define SIOC_IR_RXPOL     0
`define SIOC_IR_TXPOL     1
`define SIOC_IR_HDX       2
`define SIOC_IR_MODE_LO   3
`define SIOC_IR_MODE_HI   5
`define SIOC_IR_LOC       6
`define SIOC_IR_FUNC_STD  3'h0
`define SIOC_IR_FUNC_IRDA 3'h1

// ****************************************
// Reset values and write masks
// ****************************************
`define SIOC_RST_MODE     8'h00
`define SIOC_RST_IROPT    8'h02
`define SIOC_RST_IRTMO    8'h03
`define SIOC_RST_LDN      8'h04
`define SIOC_WM_MODE1     8'h83
`define SIOC_WM_MODE2     8'h03
`define SIOC_WM_IROPT     8'h7f

// ****************************************
// Timing
// ****************************************
`define SIOC_STEP_NS      100000
`define SIOC_CLK_NS       20

`endif

// >>> verilog/sioc_serial_ir_cfg.v
// Serial port mode and infrared option configuration with APB access
`timescale 1ns/10ps
`default_nettype none
`include "sioc_consts.vh"

module sioc_serial_ir_cfg #(
  parameter AW       = 12,
  parameter STEP_CYC = `SIOC_STEP_NS / `SIOC_CLK_NS
) (
  input  wire          clk_sys_in,
  input  wire          rst_n_in,
  // APB slave
  input  wire          psel_in,
  input  wire          penable_in,
  input  wire          pwrite_in,
  input  wire [AW-1:0] paddr_in,
  input  wire [31:0]   pwdata_in,
  output reg  [31:0]   prdata_out,
  output wire          pready_out,
  output wire          pslverr_out,
  output wire          irq_out,
  // Interrupt routing
  input  wire          first_uart_irq_in,
  input  wire          second_uart_irq_in,
  input  wire [3:0]    first_irq_pin_sel_in,
  input  wire [3:0]    second_irq_pin_sel_in,
  output reg           first_irq_req_out,
  output reg           second_irq_req_out,
  // Port mode controls
  output reg           first_midi_out,
  output reg           first_high_speed_out,
  output reg           second_midi_out,
  output reg           second_high_speed_out,
  // Second port serial path
  input  wire          second_uart_txd_in,
  input  wire          second_uart_tx_busy_in,
  output reg           second_uart_rxd_out,
  input  wire          second_port_receive_pin_in,
  input  wire          alternate_infrared_receive_pin_in,
  output reg           second_port_transmit_pin_out,
  output reg           alternate_infrared_transmit_pin_out
);

  // ****************************************
  // Functions
  // ****************************************

  // Word index from a byte address
  function [7:0] idx_of;
    input [AW-1:0] a;
    begin
      idx_of = a[9:2];
    end
  endfunction

  // Polarity apply: invert when the flag is set
  function pol;
    input d;
    input inv;
    begin
      pol = d ^ inv;
    end
  endfunction

  // Nonzero test of an 8-bit count
  function is_nz;
    input [7:0] v;
    begin
      is_nz = (v != 8'h00);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  // Device select, mode, option and timeout registers
  reg [7:0]  ldn_q;
  reg [7:0]  mode1_q;
  reg [7:0]  mode2_q;
  reg [7:0]  iropt_q;
  reg [7:0]  irtmo_q;
  // Interrupt status, its next value and mask
  reg [2:0]  ists_q;
  reg [2:0]  ists_d;
  reg [2:0]  imsk_q;

  // Last prescaler count of one 100 us step
  localparam [31:0] STEP_LAST = STEP_CYC - 1;

  // Blanking timer and edge tracking
  reg [12:0] presc_q;
  reg [7:0]  tmo_cnt_q;
  reg        tx_busy_q;
  reg        rx_prev_q;
  reg        conflict_q;

  // ****************************************
  // APB decode
  // ****************************************
  // Register index, device select and alignment
  wire [7:0] idx    = idx_of(paddr_in);
  wire       in_dev1 = (ldn_q == `SIOC_LDN_FIRST);
  wire       in_dev2 = (ldn_q == `SIOC_LDN_SECOND);
  wire       word_ok = (paddr_in[1:0] == 2'h0) &&
                       (paddr_in[AW-1:10] == {(AW-10){1'b0}});

  // Read mux results
  reg        hit;
  reg [7:0]  rd_val;

  // Read mux and address validity
  always @* begin
    hit    = 1'b0;
    rd_val = 8'h00;
    if (word_ok) begin
      case (idx)
        `SIOC_IDX_LDN: begin
          hit    = 1'b1;
          rd_val = ldn_q;
        end
        `SIOC_IDX_MODE: begin
          hit    = in_dev1 | in_dev2;
          rd_val = in_dev1 ? mode1_q : mode2_q;
        end
        `SIOC_IDX_IROPT: begin
          hit    = in_dev2;
          rd_val = iropt_q;
        end
        `SIOC_IDX_IRTMO: begin
          hit    = in_dev2;
          rd_val = irtmo_q;
        end
        `SIOC_IDX_ISTS: begin
          hit    = 1'b1;
          rd_val = {5'h00, ists_q};
        end
        `SIOC_IDX_IMSK: begin
          hit    = 1'b1;
          rd_val = {5'h00, imsk_q};
        end
        `SIOC_IDX_STATE: begin
          hit    = 1'b1;
          rd_val = {5'h00, conflict_q,
                    is_nz(tmo_cnt_q),
                    second_uart_tx_busy_in};
        end
        default: begin
          hit    = 1'b0;
          rd_val = 8'h00;
        end
      endcase
    end
  end

  // Zero wait states; error on unmapped access
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;

  // Write strobe in the access phase of a mapped register
  wire wr_en = psel_in & penable_in & pwrite_in & hit;

  // Refused reads return zero whatever the mux shows
  wire [7:0] rd_word = hit ? rd_val : 8'h00;

  // Read data captured in the setup cycle
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_out <= {24'h00_0000, rd_word};
    end
  end

  // ****************************************
  // Configuration register writes
  // ****************************************

  // Reserved bits are not stored and read zero
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ldn_q   <= `SIOC_RST_LDN;
      mode1_q <= `SIOC_RST_MODE;
      mode2_q <= `SIOC_RST_MODE;
      iropt_q <= `SIOC_RST_IROPT;
      irtmo_q <= `SIOC_RST_IRTMO;
      imsk_q  <= 3'h0;
    end else if (wr_en) begin
      case (idx)
        `SIOC_IDX_LDN:
          ldn_q <= pwdata_in[7:0];
        `SIOC_IDX_MODE: begin
          if (in_dev1)
            mode1_q <= pwdata_in[7:0] & `SIOC_WM_MODE1;
          else
            mode2_q <= pwdata_in[7:0] & `SIOC_WM_MODE2;
        end
        `SIOC_IDX_IROPT:
          iropt_q <= pwdata_in[7:0] & `SIOC_WM_IROPT;
        `SIOC_IDX_IRTMO:
          irtmo_q <= pwdata_in[7:0];
        `SIOC_IDX_IMSK:
          imsk_q <= pwdata_in[2:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Port mode outputs
  // ****************************************
  // Registered copies of mode bits 0 and 1
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_midi_out        <= 1'b0;
      first_high_speed_out  <= 1'b0;
      second_midi_out       <= 1'b0;
      second_high_speed_out <= 1'b0;
    end else begin
      first_midi_out        <= mode1_q[`SIOC_MODE_MIDI];
      first_high_speed_out  <= mode1_q[`SIOC_MODE_HS];
      second_midi_out       <= mode2_q[`SIOC_MODE_MIDI];
      second_high_speed_out <= mode2_q[`SIOC_MODE_HS];
    end
  end

  // ****************************************
  // Interrupt routing
  // ****************************************
  // Sharing bit and combined UART request
  wire share   = mode1_q[`SIOC_MODE_SHARE];
  wire any_irq = first_uart_irq_in | second_uart_irq_in;

  // Two distinct pins assigned while sharing is on
  wire conflict_now = share &&
                      (first_irq_pin_sel_in != 4'h0) &&
                      (second_irq_pin_sel_in != 4'h0) &&
                      (first_irq_pin_sel_in != second_irq_pin_sel_in);

  // Shared mode drives each port request from either UART
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_irq_req_out  <= 1'b0;
      second_irq_req_out <= 1'b0;
      conflict_q         <= 1'b0;
    end else begin
      conflict_q <= conflict_now;
      if (share) begin
        first_irq_req_out  <= any_irq;
        second_irq_req_out <= any_irq;
      end else begin
        first_irq_req_out  <= first_uart_irq_in;
        second_irq_req_out <= second_uart_irq_in;
      end
    end
  end

  // ****************************************
  // Infrared path selection
  // ****************************************
  // Option fields; polarity and pins only in infrared mode
  wire [2:0] ir_func  = iropt_q[`SIOC_IR_MODE_HI:`SIOC_IR_MODE_LO];
  wire       ir_on    = (ir_func == `SIOC_IR_FUNC_IRDA);
  wire       ir_alt   = ir_on & iropt_q[`SIOC_IR_LOC];
  wire       rx_inv   = iropt_q[`SIOC_IR_RXPOL];
  wire       tx_inv   = iropt_q[`SIOC_IR_TXPOL];
  wire       half_dx  = iropt_q[`SIOC_IR_HDX];

  // Raw receive level from the chosen pin
  wire rx_pin = ir_alt ? alternate_infrared_receive_pin_in
                       : second_port_receive_pin_in;

  // Receive polarity only in infrared mode
  wire rx_lvl = ir_on ? pol(rx_pin, rx_inv)
                      : rx_pin;

  // ****************************************
  // Half duplex blanking timer
  // ****************************************
  // Transmit end, step tick and blanking window
  wire tx_end   = tx_busy_q & ~second_uart_tx_busy_in;
  wire step     = (presc_q == STEP_LAST[12:0]);
  // Bridges the load cycle so no receive edge slips in
  wire tail_gap = tx_end & is_nz(irtmo_q);
  wire blanking = ir_on & half_dx &
                  (second_uart_tx_busy_in | tail_gap | is_nz(tmo_cnt_q));
  // Last step of the tail ends the timeout
  wire tmo_done = (tmo_cnt_q == 8'h01) & step &
                  ~second_uart_tx_busy_in;

  // Prescaler restarts with activity so each step is whole
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_q <= 13'h0000;
    end else if (second_uart_tx_busy_in | tx_end | step) begin
      presc_q <= 13'h0000;
    end else begin
      presc_q <= presc_q + 13'h0001;
    end
  end

  // Step count loaded when transmit ends
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_cnt_q <= 8'h00;
      tx_busy_q <= 1'b0;
    end else begin
      tx_busy_q <= second_uart_tx_busy_in;
      if (second_uart_tx_busy_in) begin
        tmo_cnt_q <= 8'h00;
      end else if (tx_end) begin
        tmo_cnt_q <= irtmo_q;
      end else if (step && is_nz(tmo_cnt_q)) begin
        tmo_cnt_q <= tmo_cnt_q - 8'h01;
      end
    end
  end

  // ****************************************
  // Pin drive and receive to the UART
  // ****************************************
  // Transmit level and idle level of the unused alternate pin
  wire tx_line = ir_on ? pol(second_uart_txd_in, tx_inv)
                       : second_uart_txd_in;
  wire tx_idle = ir_on ? tx_inv : 1'b1;

  // Pin drives, receive path and previous receive level
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      second_port_transmit_pin_out        <= 1'b1;
      alternate_infrared_transmit_pin_out <= 1'b1;
      second_uart_rxd_out                 <= 1'b1;
      rx_prev_q                           <= 1'b1;
    end else begin
      second_port_transmit_pin_out        <= ir_alt ? 1'b1 : tx_line;
      alternate_infrared_transmit_pin_out <= ir_alt ? tx_line
                                                    : tx_idle;
      rx_prev_q                           <= rx_lvl;
      // Receive held idle during blanking
      second_uart_rxd_out <= blanking ? 1'b1 : rx_lvl;
    end
  end

  // ****************************************
  // Interrupt status, write one to clear
  // ****************************************
  // Event sources: new conflict, blanked edge, timeout end
  wire rx_blk_ev = blanking & (rx_lvl != rx_prev_q);
  wire [2:0] ev  = {conflict_now & ~conflict_q, rx_blk_ev, tmo_done};
  wire [2:0] clr = (wr_en && idx == `SIOC_IDX_ISTS) ? pwdata_in[2:0]
                                                     : 3'h0;

  // Set wins over a clear in the same cycle
  always @* begin
    ists_d = (ists_q & ~clr) | ev;
  end

  // Status register
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ists_q <= 3'h0;
    end else begin
      ists_q <= ists_d;
    end
  end

  // Level interrupt from unmasked status bits
  assign irq_out = |(ists_q & imsk_q);

endmodule // sioc_serial_ir_cfg
`default_nettype wire

// >>> verification/sioc_serial_ir_cfg_asserts.sv
// Port-level assertions for the serial port configuration block
`timescale 1ns/10ps
`default_nettype none
module sioc_cfg_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        first_uart_irq_in,
  input wire logic        second_uart_irq_in,
  input wire logic        first_irq_req_out,
  input wire logic        second_irq_req_out,
  input wire logic        first_midi_out,
  input wire logic        first_high_speed_out,
  input wire logic        second_midi_out,
  input wire logic        second_high_speed_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Write access strobe and mode output bundle
  wire       wr_acc = psel_in && penable_in && pwrite_in;
  wire [3:0] mode_bits = {first_midi_out, first_high_speed_out, second_midi_out,
                          second_high_speed_out};
  // Bus phases
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence access_s; psel_in && penable_in; endsequence
  no_wait_a: assert property (setup_s ##1 access_s |-> pready_out)
    else $error("access phase not ready");
  err_phase_a: assert property (pslverr_out |-> access_s)
    else $error("error outside access phase");
  err_zero_a: assert property (access_s ##0 (pslverr_out && !pwrite_in) |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  rd_hold_a: assert property ($changed(prdata_out) |-> $past(psel_in && !penable_in))
    else $error("read data moved outside setup");
  own_first_a: assert property ($past(first_uart_irq_in) && $past(rst_n_in) |-> first_irq_req_out)
    else $error("first request missing");
  own_second_a: assert property ($past(second_uart_irq_in) && $past(rst_n_in) |-> second_irq_req_out)
    else $error("second request missing");
  req_cause_a: assert property (first_irq_req_out || second_irq_req_out |->
                                $past(first_uart_irq_in || second_uart_irq_in))
    else $error("request without interrupt");
  mode_write_a: assert property ($changed(mode_bits) |->
                                 $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
    else $error("mode output changed without write");
endmodule // sioc_cfg_checker
bind sioc_serial_ir_cfg sioc_cfg_checker i_sioc_cfg_checker (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .first_uart_irq_in(first_uart_irq_in),
  .second_uart_irq_in(second_uart_irq_in), .first_irq_req_out(first_irq_req_out),
  .second_irq_req_out(second_irq_req_out), .first_midi_out(first_midi_out),
  .first_high_speed_out(first_high_speed_out), .second_midi_out(second_midi_out),
  .second_high_speed_out(second_high_speed_out));
`default_nettype wire

// >>> verification/sioc_serial_ir_cfg_test.sv
// Directed testbench for the serial port configuration block
`timescale 1ns/10ps
`default_nettype none
`include "sioc_consts.vh"
module sioc_serial_ir_cfg_test;
  logic        clk_sys_in, rst_n_in, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        u1_irq, u2_irq, txd, tx_busy, rx_pin, alt_rx, req1, req2, midi1, hs1, midi2;
  logic        hs2, rxd, tx_pin, alt_tx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sel1, sel2;
  logic [7:0]  std_modes [3] = '{8'h03, 8'h18, 8'h20};
  int          failures, samples_checked;
  sioc_serial_ir_cfg #(.AW(12), .STEP_CYC(10)) i_sioc_serial_ir_cfg (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .first_uart_irq_in(u1_irq),
    .second_uart_irq_in(u2_irq), .first_irq_pin_sel_in(sel1), .second_irq_pin_sel_in(sel2),
    .first_irq_req_out(req1), .second_irq_req_out(req2), .first_midi_out(midi1),
    .first_high_speed_out(hs1), .second_midi_out(midi2), .second_high_speed_out(hs2),
    .second_uart_txd_in(txd), .second_uart_tx_busy_in(tx_busy), .second_uart_rxd_out(rxd),
    .second_port_receive_pin_in(rx_pin), .alternate_infrared_receive_pin_in(alt_rx),
    .second_port_transmit_pin_out(tx_pin), .alternate_infrared_transmit_pin_out(alt_tx));
  // Clock source
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // Wait whole cycles, then sample at the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and stop
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One bus transfer, waits boundedly for ready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (n > 16) begin
        failures++;
        end_of_test;
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {psel, penable, pwrite, u1_irq, u2_irq, tx_busy, rst_n_in} = '0;
    {txd, rx_pin, alt_rx} = '1;
    paddr = '0;
    pwdata = '0;
    sel1 = 4'h3;
    sel2 = 4'h0;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rchk("ldn", `SIOC_IDX_LDN, 8'h04);
    rchk("mode1", `SIOC_IDX_MODE, 8'h00);
    wr(`SIOC_IDX_LDN, `SIOC_LDN_SECOND);
    rchk("mode2", `SIOC_IDX_MODE, 8'h00);
    rchk("iropt", `SIOC_IDX_IROPT, 8'h02);
    rchk("irtmo", `SIOC_IDX_IRTMO, 8'h03);
    chk("idle lines", {30'h0, rxd, tx_pin}, 32'h3);
    $display("test reset done");
    wr(`SIOC_IDX_MODE, 8'hff);
    rchk("mode2 mask", `SIOC_IDX_MODE, 8'h03);
    wr(`SIOC_IDX_IROPT, 8'h80);
    rchk("iropt mask", `SIOC_IDX_IROPT, 8'h00);
    wr(`SIOC_IDX_LDN, `SIOC_LDN_FIRST);
    wr(`SIOC_IDX_MODE, 8'h7f);
    rchk("mode1 mask", `SIOC_IDX_MODE, 8'h03);
    settle(2);
    chk("mode outs", {28'h0, midi1, hs1, midi2, hs2}, 32'hf);
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b0, `SIOC_IDX_IROPT, 8'h00);
    chk("wrong device", {rd[30:0], er}, 32'h1);
    $display("test masks done");
    @(posedge clk_sys_in);
    u1_irq <= 1'b1;
    settle(2);
    chk("own irq", {30'h0, req1, req2}, 32'h2);
    wr(`SIOC_IDX_MODE, 8'h83);
    settle(2);
    chk("shared irq", {30'h0, req1, req2}, 32'h3);
    @(posedge clk_sys_in);
    sel2 <= 4'h4;
    settle(2);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rchk("conflict", `SIOC_IDX_ISTS, 8'h04);
    wr(`SIOC_IDX_IMSK, 8'h04);
    settle(1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    @(posedge clk_sys_in);
    sel2 <= 4'h0;
    u1_irq <= 1'b0;
    wr(`SIOC_IDX_ISTS, 8'h04);
    wr(`SIOC_IDX_MODE, 8'h03);
    @(posedge clk_sys_in);
    u2_irq <= 1'b1;
    settle(2);
    chk("irq cleared", {29'h0, irq, req1, req2}, 32'h1);
    $display("test interrupt done");
    wr(`SIOC_IDX_LDN, `SIOC_LDN_SECOND);
    for (int m = 0; m < 3; m++) begin
      wr(`SIOC_IDX_IROPT, std_modes[m]);
      @(posedge clk_sys_in);
      {rx_pin, txd} <= 2'b00;
      settle(2);
      chk("std path", {30'h0, rxd, tx_pin}, 32'h0);
      @(posedge clk_sys_in);
      {rx_pin, txd} <= 2'b11;
    end
    wr(`SIOC_IDX_IROPT, 8'h08);
    @(posedge clk_sys_in);
    {rx_pin, txd} <= 2'b00;
    settle(2);
    chk("ir plain", {30'h0, rxd, tx_pin}, 32'h0);
    wr(`SIOC_IDX_IROPT, 8'h0b);
    settle(2);
    chk("rx pol", {31'h0, rxd}, 32'h1);
    chk("tx pol", {31'h0, tx_pin}, 32'h1);
    wr(`SIOC_IDX_IROPT, 8'h48);
    settle(2);
    chk("idle normal tx", {31'h0, tx_pin}, 32'h1);
    chk("alt path", {30'h0, alt_tx, rxd}, 32'h1);
    $display("test infrared done");
    wr(`SIOC_IDX_IROPT, 8'h0c);
    wr(`SIOC_IDX_IRTMO, 8'h02);
    wr(`SIOC_IDX_ISTS, 8'hff);
    @(posedge clk_sys_in);
    rx_pin <= 1'b1;
    tx_busy <= 1'b1;
    settle(2);
    @(posedge clk_sys_in);
    rx_pin <= 1'b0;
    settle(2);
    chk("blank busy", {31'h0, rxd}, 32'h1);
    @(posedge clk_sys_in);
    tx_busy <= 1'b0;
    settle(15);
    chk("blank tail", {31'h0, rxd}, 32'h1);
    settle(10);
    chk("after blank", {31'h0, rxd}, 32'h0);
    rchk("blank status", `SIOC_IDX_ISTS, 8'h03);
    $display("test blanking done");
    end_of_test;
  end
endmodule // sioc_serial_ir_cfg_test
`default_nettype wire
